// ==== logic/tlt_pkg.sv ====
// shared constants for the tilt sensor serial link, both ends
// Operation
// - frame runs while chip select low
// - all serial words go MSB first
// - sensor changes MISO on SCK falling edge
// - sensor samples MOSI on SCK rising edge
// - first eight bits form the command
// - chip select rise clears counter, command
// - unknown command: ignore input, MISO floats
// - host writes data right after command
// - first answer bit after eighth rise
// - answer shifts out alongside host input
// - host keeps SCK at most 500 kHz
// - host keeps X reads under 5300/s
// - code 00 means measure, ends self test
// - code 0E starts X self test
// - code 0F starts Y self test
// - code 08 returns eight-bit temperature
// - temperature reloads 150 us, select high
// - MOSI ignored during temperature read
// - codes 10/11 return eleven-bit X/Y
// - acceleration reloads 150 us, select high
// - self-test pin forces self test on; pin here forces X only, Y by command only
// - zero tilt reads 1024
// - parity fault forces reading below 102
`default_nettype none
package tlt_pkg;
  // command codes
  localparam logic [7:0] MEASURE_MODE_CMD     = 8'h00;
  localparam logic [7:0] TEMPERATURE_READ_CMD = 8'h08;
  localparam logic [7:0] SELFTEST_X_CMD       = 8'h0E;
  localparam logic [7:0] SELFTEST_Y_CMD       = 8'h0F;
  localparam logic [7:0] ACCEL_X_READ_CMD     = 8'h10;
  localparam logic [7:0] ACCEL_Y_READ_CMD     = 8'h11;
  // word widths
  localparam int CMD_BITS   = 8;
  localparam int ACCEL_BITS = 11;
  localparam int TEMP_BITS  = 8;
  // serial self-test modes
  localparam logic [1:0] MODE_MEASURE    = 2'h0;
  localparam logic [1:0] MODE_SELFTEST_X = 2'h2;
  localparam logic [1:0] MODE_SELFTEST_Y = 2'h3;
  // data values
  localparam logic [10:0] ACCEL_ZERO_TILT = 11'h400;
  localparam logic [10:0] ACCEL_FAULT     = 11'h000;
  localparam logic [7:0]  TEMP_RESET      = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int REFRESH_NS    = 150000;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_NS   = 1000;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_NS     = 150000;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== logic/tlt_spi_if.sv ====
// serial link wires between host and tilt sensor
`timescale 1ns/10ps
`default_nettype none
interface tlt_spi_if;
  logic sck;      // serial clock from host
  logic csN;      // chip select, active low
  logic mosi;     // host to sensor data
  logic misoOut;  // sensor data value
  logic misoOeN;  // sensor drive enable, low drives
  logic miso;     // resolved line, pulled high when floating
  // wire level: a pull-up holds the line while nobody drives
  assign miso = misoOeN ? 1'b1 : misoOut;
  modport dev (input sck, input csN, input mosi, output misoOut, output misoOeN);
  modport host (output sck, output csN, output mosi, input miso);
endinterface
`default_nettype wire

// ==== logic/tlt_sensor_dev.sv ====
// tilt sensor end: serial slave on SCK, data refresh on ref_clk
`timescale 1ns/10ps
`default_nettype none
module tlt_sensor_dev
  import tlt_pkg::*;
#(
  parameter int REFRESH_CYC = REFRESH_CYCLES  // ref cycles between reloads
) (
  input  wire logic        ref_clk,         // core clock
  input  wire logic        reset,           // sync reset, active high
  tlt_spi_if.dev           spi,             // serial link
  input  wire logic        selftestPin,     // self-test pin, high forces X test
  input  wire logic        parityFault,     // config memory still bad
  input  wire logic [10:0] sampleX,         // converter result, X
  input  wire logic [10:0] sampleY,         // converter result, Y
  input  wire logic [7:0]  sampleTemp,      // converter result, temperature
  output logic             selftestXOn,     // X self test active
  output logic             selftestYOn      // Y self test active
);

  // reload counter, wide enough to reach the full period
  localparam int RW = $clog2(REFRESH_CYC + 1);

  // refuse a refresh period the counter cannot serve
  // a period of one would reload on every cycle and never settle
  if (REFRESH_CYC < 2) begin : g_chk
    $error("refresh period too short");
  end

  // ---- link domain, clocked by SCK, cleared by chip select high ----
  // no reset of its own: select high is the only clear, so a frame the
  // host cuts short never leaves a half command behind for the next one
  typedef struct packed {
    logic [3:0]  bitCnt;     // command bits taken, stops at 8
    logic [7:0]  cmdShift;   // command register
    logic        readActive; // a read answer is being shifted
    logic [10:0] txShift;    // answer word, MSB at the top
    logic        modeReq;    // mode command seen this frame
    logic [1:0]  modeCode;   // requested serial mode
  } tlt_link_s;

  tlt_link_s linkReg;   // link state
  tlt_link_s linkNext;  // link next state
  // kept apart from the struct: these two move on the opposite edge
  logic      misoOutReg;  // falling-edge data flop
  logic      misoOeNReg;  // falling-edge enable flop

  // ---- core domain, clocked by ref_clk ----
  // every register here runs on ref_clk; the link only reads the data words
  typedef struct packed {
    logic [2:0]    csSync;     // chip select synchroniser
    logic          csHigh;     // filtered chip select level
    logic [2:0]    pinSync;    // self-test pin synchroniser
    logic          pinLevel;   // filtered self-test pin
    logic [2:0]    reqSync;    // mode request synchroniser
    logic          reqLevel;   // filtered mode request
    logic [1:0]    mode;       // serial self-test mode
    logic [RW-1:0] refreshCnt; // cycles since last reload
    logic [10:0]   accelX;     // X data register
    logic [10:0]   accelY;     // Y data register
    logic [7:0]    temp;       // temperature data register
    logic          selftest_x_cmd;        // X self test output
    logic          selftest_y_cmd;        // Y self test output
  } tlt_core_s;

  tlt_core_s coreReg;   // core state
  tlt_core_s coreNext;  // core next state

  // link next state: command collect, decode, answer shift
  // the counter stops at eight, so later clocks only move the answer
  always_comb begin
    linkNext = linkReg;
    if (linkReg.bitCnt < 4'(CMD_BITS)) begin
      // command bits enter MSB first
      linkNext.cmdShift = {linkReg.cmdShift[6:0], spi.mosi};
      linkNext.bitCnt   = linkReg.bitCnt + 4'h1;
      if (linkReg.bitCnt == 4'(CMD_BITS - 1)) begin
        // eighth bit: decode the full command byte
        unique case ({linkReg.cmdShift[6:0], spi.mosi})
          MEASURE_MODE_CMD: begin
            // measure mode also ends serial self
            linkNext.modeReq  = 1'b1;
            linkNext.modeCode = MODE_MEASURE;
          end
          SELFTEST_X_CMD: begin
            linkNext.modeReq  = 1'b1;
            linkNext.modeCode = MODE_SELFTEST_X;
          end
          SELFTEST_Y_CMD: begin
            linkNext.modeReq  = 1'b1;
            linkNext.modeCode = MODE_SELFTEST_Y;
          end
          TEMPERATURE_READ_CMD: begin
            // eight bits sit at the top, low bits pad with zero
            linkNext.readActive = 1'b1;
            linkNext.txShift    = {coreReg.temp, 3'h0};
          end
          ACCEL_X_READ_CMD: begin
            linkNext.readActive = 1'b1;
            linkNext.txShift    = coreReg.accelX;
          end
          ACCEL_Y_READ_CMD: begin
            linkNext.readActive = 1'b1;
            linkNext.txShift    = coreReg.accelY;
          end
          default: begin
            // unknown code: nothing taken, line stays floating
            linkNext.readActive = 1'b0;
          end
        endcase
      end
    end else if (linkReg.readActive) begin
      // next bit moves up after the host sampled the last one
      // host data is ignored here, no command writes a register
      linkNext.txShift = {linkReg.txShift[9:0], 1'b0};
    end
  end

  // link state register; chip select high clears the frame
  // the data registers read at the eighth rise are quasi-static:
  // the core froze them several ref_clk cycles after select fell
  always_ff @(posedge spi.sck or posedge spi.csN) begin
    if (spi.csN) begin
      linkReg <= '0;
    end else begin
      linkReg <= linkNext;
    end
  end

  // answer bits change on the falling edge only
  // enable goes low, so the sensor drives, at the fall right after the eighth rise
  always_ff @(negedge spi.sck or posedge spi.csN) begin
    if (spi.csN) begin
      misoOutReg <= 1'b0;
      misoOeNReg <= 1'b1;  // float while deselected
    end else begin
      misoOutReg <= linkReg.txShift[10];
      misoOeNReg <= ~linkReg.readActive;
    end
  end

  // the line resolves in the carrier; the pull-up lives there
  assign spi.misoOut = misoOutReg;
  assign spi.misoOeN = misoOeNReg;

  // core next state: synchronisers, mode, periodic reload
  always_comb begin
    coreNext = coreReg;
    // three-flop synchronisers, first stage read by second only
    // a change counts only once the last two stages agree
    coreNext.csSync  = {coreReg.csSync[1:0], spi.csN};
    coreNext.pinSync = {coreReg.pinSync[1:0], selftestPin};
    coreNext.reqSync = {coreReg.reqSync[1:0], linkReg.modeReq};
    if (coreReg.csSync[1] == coreReg.csSync[2]) begin
      coreNext.csHigh = coreReg.csSync[2];
    end
    if (coreReg.pinSync[1] == coreReg.pinSync[2]) begin
      coreNext.pinLevel = coreReg.pinSync[2];
    end
    if (coreReg.reqSync[1] == coreReg.reqSync[2]) begin
      coreNext.reqLevel = coreReg.reqSync[2];
      // code is stable while the request level stays high; it is read
      // without a synchroniser because the request flag has already
      // crossed and the code was written in the same SCK rise as the flag
      if (coreReg.reqSync[2] && !coreReg.reqLevel) begin
        coreNext.mode = linkReg.modeCode;
      end
    end
    // reload only while select is high; low restarts the wait
    // limitation: a host that keeps select low for good sees stale data
    if (!coreReg.csHigh) begin
      coreNext.refreshCnt = '0;
    end else if (coreReg.refreshCnt == RW'(REFRESH_CYC - 1)) begin
      coreNext.refreshCnt = '0;
      coreNext.temp       = sampleTemp;
      // a lasting parity fault pins the readings low
      coreNext.accelX = parityFault ? ACCEL_FAULT : sampleX;
      coreNext.accelY = parityFault ? ACCEL_FAULT : sampleY;
    end else begin
      coreNext.refreshCnt = coreReg.refreshCnt + RW'(1);
    end
    // pin acts on X, independent of serial mode
    // Y has no pin path; only the serial command reaches it
    coreNext.selftest_x_cmd = coreReg.pinLevel || (coreReg.mode == MODE_SELFTEST_X);
    coreNext.selftest_y_cmd = (coreReg.mode == MODE_SELFTEST_Y);
  end

  // core state register
  // select counts as high in reset so the first reload is not delayed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      coreReg          <= '0;
      coreReg.csSync   <= 3'h7;
      coreReg.csHigh   <= 1'b1;
      coreReg.mode     <= MODE_MEASURE;    // measure after power-up
      coreReg.accelX   <= ACCEL_ZERO_TILT;
      coreReg.accelY   <= ACCEL_ZERO_TILT;
      coreReg.temp     <= TEMP_RESET;
    end else begin
      coreReg <= coreNext;
    end
  end

  // outputs straight from the core flops, no gate after them
  assign selftestXOn = coreReg.selftest_x_cmd;
  assign selftestYOn = coreReg.selftest_y_cmd;

endmodule
`default_nettype wire

// ==== logic/tlt_spi_host.sv ====
// host end: serial master that issues one command at a time
`timescale 1ns/10ps
`default_nettype none
module tlt_spi_host
  import tlt_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYCLES,  // ref cycles per SCK half
  parameter int GAP_CYC  = CS_GAP_CYCLES     // ref cycles select high
) (
  input  wire logic        ref_clk,   // core clock
  input  wire logic        reset,     // sync reset, active high
  tlt_spi_if.host          spi,       // serial link
  input  wire logic        cmdValid,  // command request
  input  wire logic [7:0]  cmdCode,   // command byte
  output logic             cmdReady,  // ready for a command
  output logic             rspValid,  // frame done, one pulse
  output logic [10:0]      rspData    // received word, right aligned
);

  localparam int CW = $clog2(((GAP_CYC > HALF_CYC) ? GAP_CYC : HALF_CYC) + 1);

  // refuse timings the sequencer cannot honour
  if (HALF_CYC < 2 || GAP_CYC < 2) begin : g_chk
    $error("host timing counts too short");
  end

  typedef enum logic [2:0] {
    H_GAP  = 3'h0,  // select high, waiting out the gap
    H_IDLE = 3'h1,  // waiting for a command
    H_LEAD = 3'h2,  // select low, first bit set up
    H_HIGH = 3'h3,  // SCK high phase
    H_LOW  = 3'h4,  // SCK low phase
    H_TAIL = 3'h5   // last fall done, select about to rise
  } tlt_hstate_e;

  typedef struct packed {
    tlt_hstate_e state;    // sequencer state
    logic [CW-1:0] cnt;    // phase timer
    logic [4:0]  bitIdx;   // bit being clocked
    logic [4:0]  nBits;    // bits in this frame
    logic [7:0]  cmd;      // outgoing command shift
    logic [10:0] rx;       // incoming answer shift
    logic [2:0]  misoSync; // MISO synchroniser
    logic        misoLvl;  // filtered MISO
    logic        sck;      // serial clock out
    logic        csN;      // chip select out
    logic        mosi;     // data out
    logic        ready;    // command port ready
    logic        rspV;     // answer pulse
    logic [10:0] rspD;     // answer word
  } tlt_host_s;

  tlt_host_s hReg;   // host state
  tlt_host_s hNext;  // host next state

  // sequencer next state
  always_comb begin
    hNext = hReg;
    hNext.rspV = 1'b0;
    hNext.cnt  = hReg.cnt + CW'(1);
    hNext.misoSync = {hReg.misoSync[1:0], spi.miso};
    if (hReg.misoSync[1] == hReg.misoSync[2]) begin
      hNext.misoLvl = hReg.misoSync[2];
    end
    unique case (hReg.state)
      H_GAP: begin
        // long gap lets the sensor reload before any read
        // with ~40 us per frame this also keeps reads under 5300/s
        if (hReg.cnt == CW'(GAP_CYC - 1)) begin
          hNext.state = H_IDLE;
          hNext.ready = 1'b1;
        end
      end
      H_IDLE: begin
        hNext.cnt = '0;
        if (cmdValid) begin
          // select falls and MSB is presented
          hNext.state  = H_LEAD;
          hNext.ready  = 1'b0;
          hNext.csN    = 1'b0;
          hNext.cmd    = cmdCode;
          hNext.mosi   = cmdCode[7];
          hNext.bitIdx = '0;
          hNext.rx     = '0;
          // reads add their answer bits to the command byte
          if (cmdCode == ACCEL_X_READ_CMD || cmdCode == ACCEL_Y_READ_CMD) begin
            hNext.nBits = 5'(CMD_BITS + ACCEL_BITS);
          end else if (cmdCode == TEMPERATURE_READ_CMD) begin
            hNext.nBits = 5'(CMD_BITS + TEMP_BITS);
          end else begin
            hNext.nBits = 5'(CMD_BITS);
          end
        end
      end
      H_LEAD, H_LOW: begin
        // half period of at least 1 us keeps SCK at 500 kHz or less
        if (hReg.cnt == CW'(HALF_CYC - 1)) begin
          hNext.cnt   = '0;
          hNext.sck   = 1'b1;  // data stable well before the rise
          hNext.state = H_HIGH;
          if (hReg.bitIdx >= 5'(CMD_BITS)) begin
            // sampled late in the low phase, after the sensor's fall
            hNext.rx = {hReg.rx[9:0], hReg.misoLvl};
          end
        end
      end
      H_HIGH: begin
        if (hReg.cnt == CW'(HALF_CYC - 1)) begin
          hNext.cnt = '0;
          hNext.sck = 1'b0;
          if (hReg.bitIdx == hReg.nBits - 5'h1) begin
            hNext.state = H_TAIL;
          end else begin
            // next bit right away, zeros after the command
            hNext.state  = H_LOW;
            hNext.bitIdx = hReg.bitIdx + 5'h1;
            hNext.cmd    = {hReg.cmd[6:0], 1'b0};
            hNext.mosi   = hReg.cmd[6];
          end
        end
      end
      H_TAIL: begin
        if (hReg.cnt == CW'(HALF_CYC - 1)) begin
          // select rises, frame over
          hNext.cnt   = '0;
          hNext.csN   = 1'b1;
          hNext.mosi  = 1'b0;
          hNext.rspV  = 1'b1;
          hNext.rspD  = hReg.rx;
          hNext.state = H_GAP;
        end
      end
      default: begin
        hNext.state = H_GAP;
        hNext.csN   = 1'b1;
        hNext.sck   = 1'b0;
      end
    endcase
  end

  // host state register; starts with a gap so the first read is valid
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hReg          <= '0;
      hReg.state    <= H_GAP;
      hReg.csN      <= 1'b1;
      hReg.misoSync <= 3'h7;
      hReg.misoLvl  <= 1'b1;
    end else begin
      hReg <= hNext;
    end
  end

  assign spi.sck  = hReg.sck;
  assign spi.csN  = hReg.csN;
  assign spi.mosi = hReg.mosi;
  assign cmdReady = hReg.ready;
  assign rspValid = hReg.rspV;
  assign rspData  = hReg.rspD;

endmodule
`default_nettype wire

// ==== verification/tlt_spi_checker.sv ====
// concurrent checks on the serial link between host and sensor
`timescale 1ns/10ps
`default_nettype none
module tlt_spi_checker
  import tlt_pkg::*;
#(
  parameter int GAP_CYC = CS_GAP_CYCLES  // ref cycles select high
) (
  input wire logic ref_clk,  // core clock
  input wire logic reset,    // sync reset, active high
  input wire logic sck,      // serial clock
  input wire logic csN,      // chip select, active low
  input wire logic mosi,     // host data
  input wire logic misoOut,  // sensor data value
  input wire logic misoOeN,  // sensor drive enable, low drives
  input wire logic miso      // resolved line
);
  // frame tracking as seen from ref_clk samples
  typedef struct packed {
    logic [5:0]  riseCnt;  // sck rises in this frame
    logic [7:0]  cmd;      // command shifted in
    logic [15:0] highCnt;  // samples with select high
    logic        sckPrev;  // sck one sample back
  } tlt_chk_s;
  tlt_chk_s stReg;    // registered tracker
  tlt_chk_s stNext;   // next tracker value
  logic     isRead;   // command asks for an answer
  assign isRead = (stReg.cmd == ACCEL_X_READ_CMD) || (stReg.cmd == ACCEL_Y_READ_CMD)
                  || (stReg.cmd == TEMPERATURE_READ_CMD);
  // next state: rise count and command clear while deselected, like the sensor's own
  always_comb begin
    stNext = stReg;
    stNext.sckPrev = sck;
    if (csN) begin
      stNext.riseCnt = 6'h00;
      stNext.cmd = 8'h00;
      // saturate so a long idle never wraps to a short gap
      if (stReg.highCnt != 16'hFFFF) begin
        stNext.highCnt = stReg.highCnt + 16'h0001;
      end
    end else begin
      stNext.highCnt = 16'h0000;
      if (sck && !stReg.sckPrev && stReg.riseCnt != 6'h3F) begin
        stNext.riseCnt = stReg.riseCnt + 6'h01;
        if (stReg.riseCnt < 6'h08) begin
          stNext.cmd = {stReg.cmd[6:0], mosi};
        end
      end
    end
  end
  // register the tracker
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_floatWhenDeselected;
    csN |-> misoOeN && miso;
  endproperty
  a_floatWhenDeselected: assert property (p_floatWhenDeselected)
    else $error("miso driven while deselected");
  property p_misoOnFall;
    !csN && !misoOeN && $changed(misoOut) |-> $fell(sck);
  endproperty
  a_misoOnFall: assert property (p_misoOnFall)
    else $error("miso changed away from an sck fall");
  property p_mosiStable;
    !csN && $rose(sck) |-> $stable(mosi);
  endproperty
  a_mosiStable: assert property (p_mosiStable)
    else $error("mosi moved at an sck rise");
  property p_sckInFrame;
    $rose(sck) |-> !csN && !$past(csN, 4);
  endproperty
  a_sckInFrame: assert property (p_sckInFrame)
    else $error("sck rose outside a frame");
  property p_firstBit;
    $fell(misoOeN) |-> $fell(sck) && stReg.riseCnt == 6'h08;
  endproperty
  a_firstBit: assert property (p_firstBit)
    else $error("answer did not start at the fall after the eighth rise");
  property p_quietDuringCommand;
    !csN && stReg.riseCnt < 6'h08 |-> misoOeN;
  endproperty
  a_quietDuringCommand: assert property (p_quietDuringCommand)
    else $error("miso driven before the command was complete");
  property p_unknownFloats;
    !csN && stReg.riseCnt >= 6'h08 && !isRead |-> misoOeN;
  endproperty
  a_unknownFloats: assert property (p_unknownFloats)
    else $error("miso driven after a command without answer");
  property p_readDrives;
    !csN && isRead && stReg.riseCnt >= 6'h09 |-> !misoOeN;
  endproperty
  a_readDrives: assert property (p_readDrives)
    else $error("read answer not driven while clocks run");
  property p_gapBeforeFrame;
    $fell(csN) |-> int'(stReg.highCnt) >= GAP_CYC;
  endproperty
  a_gapBeforeFrame: assert property (p_gapBeforeFrame)
    else $error("select high gap too short before a frame");
endmodule
`default_nettype wire

// ==== verification/tilt_sensor_spi_readout_tb_top.sv ====
// self-checking bench: host and sensor joined on one link
`timescale 1ns/10ps
`default_nettype none
module tilt_sensor_spi_readout_tb_top;
  import tlt_pkg::*;
  localparam int          HALF    = 8;        // sck half period, shortened
  localparam int          GAP     = 60;       // select gap, must beat reload
  localparam int          REFRESH = 50;       // reload period, shortened
  localparam logic [10:0] X_VAL   = 11'h5A3;  // x converter value
  localparam logic [10:0] Y_VAL   = 11'h2C6;  // y converter value
  localparam logic [7:0]  T_VAL   = 8'hB4;    // temperature value
  typedef struct packed {
    logic [7:0]  code;  // command byte
    logic [10:0] data;  // expected answer word
    logic [5:0]  bits;  // expected sck rises
    logic        selftest_x_cmd;   // expected x self test
    logic        selftest_y_cmd;   // expected y self test
  } tlt_row_s;
  // ordinary cases; the unknown code must leave the y mode alone
  tlt_row_s rows [7] = '{
    '{ACCEL_X_READ_CMD, X_VAL, 6'h13, 1'b0, 1'b0},
    '{ACCEL_Y_READ_CMD, Y_VAL, 6'h13, 1'b0, 1'b0},
    '{TEMPERATURE_READ_CMD, {3'h0, T_VAL}, 6'h10, 1'b0, 1'b0},
    '{SELFTEST_X_CMD, 11'h000, 6'h08, 1'b1, 1'b0},
    '{SELFTEST_Y_CMD, 11'h000, 6'h08, 1'b0, 1'b1},
    '{8'h55, 11'h000, 6'h08, 1'b0, 1'b1},
    '{MEASURE_MODE_CMD, 11'h000, 6'h08, 1'b0, 1'b0}};
  logic        ref_clk = 1'b0;  // core clock
  logic        reset;           // sync reset
  logic        selftestPin;     // self-test pin
  logic        parityFault;     // config fault
  logic [10:0] sampleX;         // converter x
  logic [10:0] sampleY;         // converter y
  logic [7:0]  sampleTemp;      // converter temperature
  logic        selftestXOn;     // x self test state
  logic        selftestYOn;     // y self test state
  logic        cmdValid;        // command request
  logic [7:0]  cmdCode;         // command byte
  logic        cmdReady;        // host ready
  logic        rspValid;        // frame done
  logic [10:0] rspData;         // answer word
  logic [31:0] wireMosi;        // mosi bits seen on the wire
  logic [31:0] wireMiso;        // miso bits seen on the wire
  logic [5:0]  wireBits;        // rises seen in the frame
  int          bad_count = 0;   // mismatches
  int          checked = 0;     // comparisons
  int          n;               // wait counter
  always #4 ref_clk = ~ref_clk;
  tlt_spi_if tlt_spi_if_inst ();
  tlt_sensor_dev #(.REFRESH_CYC(REFRESH)) tlt_sensor_dev_inst (.ref_clk(ref_clk), .reset(reset),
    .spi(tlt_spi_if_inst), .selftestPin(selftestPin), .parityFault(parityFault), .sampleX(sampleX),
    .sampleY(sampleY), .sampleTemp(sampleTemp), .selftestXOn(selftestXOn), .selftestYOn(selftestYOn));
  tlt_spi_host #(.HALF_CYC(HALF), .GAP_CYC(GAP)) tlt_spi_host_inst (.ref_clk(ref_clk), .reset(reset),
    .spi(tlt_spi_if_inst), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData));
  tlt_spi_checker #(.GAP_CYC(GAP)) tlt_spi_checker_inst (.ref_clk(ref_clk), .reset(reset),
    .sck(tlt_spi_if_inst.sck), .csN(tlt_spi_if_inst.csN), .mosi(tlt_spi_if_inst.mosi),
    .misoOut(tlt_spi_if_inst.misoOut), .misoOeN(tlt_spi_if_inst.misoOeN), .miso(tlt_spi_if_inst.miso));
  // wire monitor: both lines sampled where the sensor samples mosi;
  // a select fall, with sck idle low, starts the record afresh
  always @(posedge tlt_spi_if_inst.sck or negedge tlt_spi_if_inst.csN) begin
    if (!tlt_spi_if_inst.sck) begin
      wireMosi <= '0;
      wireMiso <= '0;
      wireBits <= '0;
    end else if (!tlt_spi_if_inst.csN) begin
      wireMosi <= {wireMosi[30:0], tlt_spi_if_inst.mosi};
      wireMiso <= {wireMiso[30:0], tlt_spi_if_inst.miso};
      wireBits <= wireBits + 6'h01;
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      bad_count++;
    end
  endtask
  // a wait that ran out ends the run
  task automatic wait_cut(input int lim);
    if (n >= lim) begin
      $display("wrong value at %0t: wait ran out", $time);
      bad_count++;
      give_verdict();
    end
  endtask
  // one command through the host port, returns after the answer pulse
  task automatic run_cmd(input logic [7:0] code);
    n = 0;
    while (cmdReady !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    wait_cut(3000);
    cmdCode = code;
    cmdValid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    wait_cut(1000);
  endtask
  initial begin
    reset = 1'b1;
    selftestPin = 1'b0;
    parityFault = 1'b0;
    sampleX = X_VAL;
    sampleY = Y_VAL;
    sampleTemp = T_VAL;
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    check(32'(selftestXOn), 32'h0, "x test after reset");
    check(32'(tlt_spi_if_inst.miso), 32'h1, "idle line");
    // table: answers, wire order, clock counts and modes
    foreach (rows[i]) begin
      run_cmd(rows[i].code);
      check(32'(rspData), 32'(rows[i].data), "answer word");
      check(32'(wireBits), 32'(rows[i].bits), "clock count");
      check((wireMosi >> (rows[i].bits - 6'h08)) & 32'h0000_00FF, 32'(rows[i].code), "mosi order");
      check(wireMiso & ((32'h1 << rows[i].bits) - 32'h1),
            (32'h0000_00FF << (rows[i].bits - 6'h08)) | 32'(rows[i].data), "miso order");
      check(32'(selftestXOn), 32'(rows[i].selftest_x_cmd), "x test mode");
      check(32'(selftestYOn), 32'(rows[i].selftest_y_cmd), "y test mode");
    end
    // pin forces x self test, tried here with the serial mode left at measure
    selftestPin = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check(32'(selftestXOn), 32'h1, "pin self test on");
    selftestPin = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    check(32'(selftestXOn), 32'h0, "pin self test off");
    // config fault pushes the reading out of range, then recovers
    parityFault = 1'b1;
    run_cmd(ACCEL_X_READ_CMD);
    check(32'(rspData < 11'h066), 32'h1, "fault reading low");
    parityFault = 1'b0;
    sampleX = 11'h001;
    run_cmd(ACCEL_X_READ_CMD);
    check(32'(rspData), 32'h001, "reloaded x word");
    // reset in mid-run drops serial self test
    run_cmd(SELFTEST_X_CMD);
    check(32'(selftestXOn), 32'h1, "x test before reset");
    // a fresh temperature proves the reload after reset
    sampleTemp = 8'h3C;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    check(32'(selftestXOn), 32'h0, "x test after second reset");
    run_cmd(TEMPERATURE_READ_CMD);
    check(32'(rspData), 32'h03C, "temperature after reset");
    give_verdict();
  end
endmodule
`default_nettype wire
